// ==== design/cto_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cto_regs.svh"

// Function
// RULE_01: Opcode 97 copies the accumulator into the index low byte in one cycle, flags untouched.
// RULE_02: Opcode 85 loads the accumulator with the condition flags register in one cycle, flags untouched.
// RULE_03: The test sets negative and zero from the operand, clears overflow, keeps other flags, stores nothing.
// RULE_04: Test opcodes are 3D direct, 4D accumulator, 5D index low, 6D 8-bit indexed, 7D indexed, 9E 6D stack.
// RULE_05: Opcode 95 loads the index pair with stack pointer plus one in two cycles, flags untouched.
// RULE_06: Opcode 9F copies the index low byte into the accumulator in one cycle, flags untouched.
// RULE_07: Opcode 94 loads the stack pointer with index pair minus one in two cycles, flags untouched.
// RULE_08: Stack 8-bit offset mode addresses stack pointer plus one unsigned stream byte.
// RULE_09: Stack 16-bit offset mode addresses stack pointer plus a two-byte stream offset.
// RULE_10: Indexed post-increment mode addresses the index pair and then increments it.
// RULE_11: Indexed 8-bit offset post-increment mode addresses index pair plus offset, then increments the pair.
// RULE_12: Direct-to-indexed move reads a direct byte, writes it at the index pair, then increments the pair.
// RULE_13: Indexed-to-direct move reads at the index pair, increments the pair, writes to a direct address.
// RULE_14: Immediate-to-direct move stores the stream immediate byte at the given direct address.
// RULE_15: Extended mode fetches a 16-bit address, high byte first then low byte.
// RULE_16: 16-bit offset indexed mode fetches offset high then low and adds it to the index pair.
// RULE_17: Compare-and-branch on a direct operand carries a direct address byte then a signed displacement byte.
module cto_core (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                instValid,
  input  wire logic [7:0]          instByte,
  input  wire logic                svcValid,
  input  wire cto_pkg::cto_mode_t  svcMode,
  input  wire logic [7:0]          memRdata,
  output logic                     instReady,
  output logic [15:0]              svcAddr,
  output logic                     svcDone,
  output cto_pkg::cto_mem_t        mem,
  output cto_pkg::cto_regs_t       regs,
  output cto_pkg::cto_branch_t     branch,
  output logic                     opDone,
  output logic                     opUnknown
);

  typedef enum logic [2:0] {ST_IDLE, ST_PREFIX, ST_FETCH, ST_READ, ST_WAIT, ST_EXEC, ST_WRITE} cto_state_t;

  cto_state_t          state;
  cto_state_t          next_state;
  cto_pkg::cto_op_t    op;
  cto_pkg::cto_mode_t  mode;
  cto_pkg::cto_dec_t   dec;
  logic [1:0]          needBytes;
  logic [1:0]          byteCount;
  logic [7:0]          byteOne;
  logic [7:0]          byteTwo;
  logic [7:0]          acc;
  logic [7:0]          idxHigh;
  logic [7:0]          idxLow;
  logic [15:0]         stackPtr;
  logic [7:0]          condition_flags_register;
  logic [15:0]         indexPair;
  logic [15:0]         effAddr;
  logic [7:0]          flagValue;
  logic [7:0]          testedCcr;
  logic                isEqual;
  logic                takeInst;
  logic                takeSvc;
  logic                fetchLast;

  function automatic logic [1:0] modeBytes(input cto_pkg::cto_mode_t m);
    case (m)
      cto_pkg::MODE_EXTENDED_ADDRESS, cto_pkg::MODE_INDEXED_OFF16, cto_pkg::MODE_STACK_OFFSET16:
        modeBytes = 2'd2;
      cto_pkg::MODE_DIRECT, cto_pkg::MODE_INDEXED_OFF8, cto_pkg::MODE_STACK_OFFSET8,
      cto_pkg::MODE_INDEXED_OFF8_POSTINC:
        modeBytes = 2'd1;
      default:
        modeBytes = 2'd0;
    endcase
  endfunction

  function automatic cto_pkg::cto_dec_t decodeOp(input logic [7:0] code, input logic prefixed);
    cto_pkg::cto_dec_t d;
    d.op = cto_pkg::OP_NONE;
    d.mode = cto_pkg::MODE_INHERENT;
    d.nBytes = 2'd0;
    if (prefixed)
    begin
      // RULE_04 stack form after prefix
      if (code == `CTO_OPC_CHECK_IX1)
      begin
        d.op = cto_pkg::OP_CHECK_MEM;
        d.mode = cto_pkg::MODE_STACK_OFFSET8;
      end
    end
    else
    begin
      // RULE_04 test opcode decode
      case (code)
        `CTO_OPC_ACC_TO_IDX:   d.op = cto_pkg::OP_ACC_TO_IDX;
        `CTO_OPC_FLAGS_TO_ACC: d.op = cto_pkg::OP_FLAGS_TO_ACC;
        `CTO_OPC_IDX_TO_ACC:   d.op = cto_pkg::OP_IDX_TO_ACC;
        `CTO_OPC_SP_TO_HX:     d.op = cto_pkg::OP_SP_TO_HX;
        `CTO_OPC_HX_TO_SP:     d.op = cto_pkg::OP_HX_TO_SP;
        `CTO_OPC_CHECK_ACC:    d.op = cto_pkg::OP_CHECK_ACC;
        `CTO_OPC_CHECK_IDX:    d.op = cto_pkg::OP_CHECK_IDX;
        `CTO_OPC_CHECK_DIR:    {d.op, d.mode} = {cto_pkg::OP_CHECK_MEM, cto_pkg::MODE_DIRECT};
        `CTO_OPC_CHECK_IX1:    {d.op, d.mode} = {cto_pkg::OP_CHECK_MEM, cto_pkg::MODE_INDEXED_OFF8};
        `CTO_OPC_CHECK_IX:     {d.op, d.mode} = {cto_pkg::OP_CHECK_MEM, cto_pkg::MODE_INDEXED};
        `CTO_OPC_CMPBR_DIR:    {d.op, d.mode} = {cto_pkg::OP_CMPBR, cto_pkg::MODE_DIRECT};
        `CTO_OPC_CMPBR_IX1P:   {d.op, d.mode} = {cto_pkg::OP_CMPBR, cto_pkg::MODE_INDEXED_OFF8_POSTINC};
        `CTO_OPC_CMPBR_IXP:    {d.op, d.mode} = {cto_pkg::OP_CMPBR, cto_pkg::MODE_INDEXED_POSTINC};
        `CTO_OPC_MOVE_DIXP:    {d.op, d.mode} = {cto_pkg::OP_MOVE_DIXP, cto_pkg::MODE_DIRECT};
        `CTO_OPC_MOVE_IXPD:    {d.op, d.mode} = {cto_pkg::OP_MOVE_IXPD, cto_pkg::MODE_INDEXED_POSTINC};
        `CTO_OPC_MOVE_IMD:     {d.op, d.mode} = {cto_pkg::OP_MOVE_IMD, cto_pkg::MODE_INHERENT};
        default:               d.op = cto_pkg::OP_NONE;
      endcase
    end
    d.nBytes = modeBytes(d.mode);
    // RULE_17 displacement follows operand byte
    if (d.op == cto_pkg::OP_CMPBR)
      d.nBytes = d.nBytes + 2'd1;
    if (d.op == cto_pkg::OP_MOVE_IXPD)
      d.nBytes = 2'd1;
    if (d.op == cto_pkg::OP_MOVE_IMD)
      d.nBytes = 2'd2;
    decodeOp = d;
  endfunction

  function automatic cto_state_t afterFetch(input cto_pkg::cto_op_t o);
    case (o)
      cto_pkg::OP_MOVE_IMD:
        afterFetch = ST_WRITE;
      cto_pkg::OP_SVC, cto_pkg::OP_SP_TO_HX, cto_pkg::OP_HX_TO_SP:
        afterFetch = ST_EXEC;
      default:
        afterFetch = ST_READ;
    endcase
  endfunction

  function automatic logic isSingle(input cto_pkg::cto_op_t o);
    isSingle = (o == cto_pkg::OP_ACC_TO_IDX) || (o == cto_pkg::OP_FLAGS_TO_ACC) ||
               (o == cto_pkg::OP_IDX_TO_ACC) || (o == cto_pkg::OP_CHECK_ACC) ||
               (o == cto_pkg::OP_CHECK_IDX);
  endfunction

  assign indexPair = {idxHigh, idxLow};
  assign regs = {acc, idxHigh, idxLow, stackPtr, condition_flags_register};
  assign takeInst = instValid && instReady;
  assign takeSvc = svcValid && !instValid && (state == ST_IDLE);
  assign dec = decodeOp(instByte, state == ST_PREFIX);
  assign fetchLast = (state == ST_FETCH) && takeInst && ((byteCount + 2'd1) == needBytes);
  assign flagValue = (state == ST_EXEC) ? memRdata : ((dec.op == cto_pkg::OP_CHECK_IDX) ? idxLow : acc);

  cto_addr_gen i_cto_addr_gen (
    .mode      (mode),
    .indexPair (indexPair),
    .stackPtr  (stackPtr),
    .byteOne   (byteOne),
    .byteTwo   (byteTwo),
    .addr      (effAddr)
  );

  cto_flag_eval i_cto_flag_eval (
    .value       (flagValue),
    .ccrIn       (condition_flags_register),
    .compareWith (acc),
    .ccrOut      (testedCcr),
    .isEqual     (isEqual)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (takeInst)
        begin
          if (instByte == `CTO_OPC_STACK_PREFIX)
            next_state = ST_PREFIX;
          else if (dec.op == cto_pkg::OP_NONE || isSingle(dec.op))
            next_state = ST_IDLE;
          else if (dec.nBytes != 2'd0)
            next_state = ST_FETCH;
          else
            next_state = afterFetch(dec.op);
        end
        else if (takeSvc)
          next_state = (modeBytes(svcMode) != 2'd0) ? ST_FETCH : ST_EXEC;
      ST_PREFIX:
        if (takeInst)
          next_state = (dec.op == cto_pkg::OP_NONE) ? ST_IDLE : ST_FETCH;
      ST_FETCH:
        if (fetchLast)
          next_state = afterFetch(op);
      ST_READ:
        next_state = ST_WAIT;
      ST_WAIT:
        next_state = ST_EXEC;
      ST_EXEC:
        next_state = (op == cto_pkg::OP_MOVE_DIXP || op == cto_pkg::OP_MOVE_IXPD) ? ST_WRITE : ST_IDLE;
      ST_WRITE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Ready follows the state we enter, so the sequencer never sees a stale grant
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      instReady <= 1'b0;
    else
      instReady <= (next_state == ST_IDLE) || (next_state == ST_PREFIX) || (next_state == ST_FETCH);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      op <= cto_pkg::OP_NONE;
      mode <= cto_pkg::MODE_INHERENT;
      needBytes <= 2'd0;
      byteCount <= 2'd0;
      byteOne <= 8'h00;
      byteTwo <= 8'h00;
    end
    else if ((state == ST_IDLE || state == ST_PREFIX) && takeInst)
    begin
      op <= dec.op;
      mode <= dec.mode;
      needBytes <= dec.nBytes;
      byteCount <= 2'd0;
    end
    else if (takeSvc)
    begin
      op <= cto_pkg::OP_SVC;
      mode <= svcMode;
      needBytes <= modeBytes(svcMode);
      byteCount <= 2'd0;
    end
    else if (state == ST_FETCH && takeInst)
    begin
      // RULE_15 first byte is the high byte
      if (byteCount == 2'd0)
        byteOne <= instByte;
      else
        byteTwo <= instByte;
      byteCount <= byteCount + 2'd1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      acc <= `CTO_RST_ACC;
      {idxHigh, idxLow} <= `CTO_RST_IDX;
      stackPtr <= `CTO_RST_SP;
      condition_flags_register <= `CTO_RST_CCR;
    end
    else if (state == ST_IDLE && takeInst)
    begin
      case (dec.op)
        // RULE_01 acc to index low
        cto_pkg::OP_ACC_TO_IDX:   idxLow <= acc;
        // RULE_02 flags to acc
        cto_pkg::OP_FLAGS_TO_ACC: acc <= condition_flags_register;
        // RULE_06 index low to acc
        cto_pkg::OP_IDX_TO_ACC:   acc <= idxLow;
        // RULE_03 register test
        cto_pkg::OP_CHECK_ACC, cto_pkg::OP_CHECK_IDX:
          condition_flags_register <= testedCcr;
        default:
          condition_flags_register <= condition_flags_register;
      endcase
    end
    else if (state == ST_EXEC)
    begin
      case (op)
        // RULE_05 stack plus one
        cto_pkg::OP_SP_TO_HX: {idxHigh, idxLow} <= stackPtr + 16'h0001;
        // RULE_07 index pair minus one
        cto_pkg::OP_HX_TO_SP: stackPtr <= indexPair - 16'h0001;
        // RULE_03 memory test, no store
        cto_pkg::OP_CHECK_MEM: condition_flags_register <= testedCcr;
        default:
          condition_flags_register <= condition_flags_register;
      endcase
      // RULE_10 increment after use
      if (op != cto_pkg::OP_SVC &&
          (mode == cto_pkg::MODE_INDEXED_POSTINC || mode == cto_pkg::MODE_INDEXED_OFF8_POSTINC))
        {idxHigh, idxLow} <= indexPair + 16'h0001;
    end
    // RULE_12 increment after the write
    else if (state == ST_WRITE && op == cto_pkg::OP_MOVE_DIXP)
      {idxHigh, idxLow} <= indexPair + 16'h0001;
  end

  // Memory data is expected the cycle after the read strobe; no wait states
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mem <= '0;
    else
    begin
      mem.rd <= 1'b0;
      mem.wr <= 1'b0;
      if (state == ST_READ)
      begin
        mem.rd <= 1'b1;
        mem.addr <= effAddr;
      end
      // RULE_14 immediate to direct page
      else if (fetchLast && op == cto_pkg::OP_MOVE_IMD)
      begin
        mem.wr <= 1'b1;
        mem.addr <= {`CTO_DIRECT_PAGE, instByte};
        mem.wdata <= byteOne;
      end
      // RULE_12 direct byte to index pair
      else if (state == ST_EXEC && op == cto_pkg::OP_MOVE_DIXP)
      begin
        mem.wr <= 1'b1;
        mem.addr <= indexPair;
        mem.wdata <= memRdata;
      end
      // RULE_13 indexed byte to direct page
      else if (state == ST_EXEC && op == cto_pkg::OP_MOVE_IXPD)
      begin
        mem.wr <= 1'b1;
        mem.addr <= {`CTO_DIRECT_PAGE, byteOne};
        mem.wdata <= memRdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      opDone <= 1'b0;
      opUnknown <= 1'b0;
      svcDone <= 1'b0;
      svcAddr <= 16'h0000;
      branch <= '0;
    end
    else
    begin
      opDone <= ((state == ST_IDLE) && takeInst && isSingle(dec.op)) ||
                ((state == ST_EXEC) && next_state == ST_IDLE && op != cto_pkg::OP_SVC) ||
                (state == ST_WRITE);
      opUnknown <= (state == ST_IDLE || state == ST_PREFIX) && takeInst &&
                   dec.op == cto_pkg::OP_NONE && !(state == ST_IDLE && instByte == `CTO_OPC_STACK_PREFIX);
      svcDone <= (state == ST_EXEC) && (op == cto_pkg::OP_SVC);
      if (state == ST_EXEC && op == cto_pkg::OP_SVC)
        svcAddr <= effAddr;
      branch.valid <= (state == ST_EXEC) && (op == cto_pkg::OP_CMPBR);
      if (state == ST_EXEC && op == cto_pkg::OP_CMPBR)
      begin
        // RULE_17 displacement is the last stream byte
        branch.taken <= isEqual;
        branch.disp <= (mode == cto_pkg::MODE_INDEXED_POSTINC) ? byteOne : byteTwo;
      end
    end
  end

endmodule
`default_nettype wire

// ==== design/cto_regs.svh ====
`ifndef CTO_REGS_SVH
`define CTO_REGS_SVH

// Opcodes handled by this slice
`define CTO_OPC_ACC_TO_IDX    8'h97
`define CTO_OPC_FLAGS_TO_ACC  8'h85
`define CTO_OPC_IDX_TO_ACC    8'h9f
`define CTO_OPC_SP_TO_HX      8'h95
`define CTO_OPC_HX_TO_SP      8'h94
`define CTO_OPC_CHECK_DIR     8'h3d
`define CTO_OPC_CHECK_ACC     8'h4d
`define CTO_OPC_CHECK_IDX     8'h5d
`define CTO_OPC_CHECK_IX1     8'h6d
`define CTO_OPC_CHECK_IX      8'h7d
`define CTO_OPC_STACK_PREFIX  8'h9e
`define CTO_OPC_CMPBR_DIR     8'h31
`define CTO_OPC_CMPBR_IX1P    8'h61
`define CTO_OPC_CMPBR_IXP     8'h71
`define CTO_OPC_MOVE_DIXP     8'h5e
`define CTO_OPC_MOVE_IMD      8'h6e
`define CTO_OPC_MOVE_IXPD     8'h7e

// Condition flag bit positions
`define CTO_CCR_V             7
`define CTO_CCR_N             2
`define CTO_CCR_Z             1

// Reset values
`define CTO_RST_CCR           8'h68
`define CTO_RST_ACC           8'h00
`define CTO_RST_IDX           16'h0000
`define CTO_RST_SP            16'h00ff

// Direct page sits in the first 256 bytes
`define CTO_DIRECT_PAGE       8'h00

`endif

// ==== design/cto_pkg.sv ====
`default_nettype none
package cto_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_ACC_TO_IDX, OP_FLAGS_TO_ACC, OP_IDX_TO_ACC, OP_CHECK_ACC, OP_CHECK_IDX,
    OP_CHECK_MEM, OP_SP_TO_HX, OP_HX_TO_SP, OP_CMPBR, OP_MOVE_DIXP, OP_MOVE_IXPD,
    OP_MOVE_IMD, OP_SVC
  } cto_op_t;

  typedef enum logic [3:0] {
    MODE_INHERENT, MODE_DIRECT, MODE_INDEXED, MODE_INDEXED_OFF8, MODE_STACK_OFFSET8,
    MODE_STACK_OFFSET16, MODE_EXTENDED_ADDRESS, MODE_INDEXED_OFF16, MODE_INDEXED_POSTINC,
    MODE_INDEXED_OFF8_POSTINC
  } cto_mode_t;

  typedef struct packed {
    cto_op_t    op;
    cto_mode_t  mode;
    logic [1:0] nBytes;
  } cto_dec_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cto_mem_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idxHigh;
    logic [7:0]  idxLow;
    logic [15:0] stackPtr;
    logic [7:0]  condition_flags_register;
  } cto_regs_t;

  typedef struct packed {
    logic       valid;
    logic       taken;
    logic [7:0] disp;
  } cto_branch_t;

endpackage
`default_nettype wire

// ==== design/cto_addr_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cto_regs.svh"

module cto_addr_gen (
  input  wire cto_pkg::cto_mode_t mode,
  input  wire logic [15:0]        indexPair,
  input  wire logic [15:0]        stackPtr,
  input  wire logic [7:0]         byteOne,
  input  wire logic [7:0]         byteTwo,
  output logic [15:0]             addr
);

  always_comb
  begin
    case (mode)
      cto_pkg::MODE_DIRECT:
        addr = {`CTO_DIRECT_PAGE, byteOne};
      // RULE_08 unsigned stack offset
      cto_pkg::MODE_STACK_OFFSET8:
        addr = stackPtr + {8'h00, byteOne};
      // RULE_09 two-byte stack offset
      cto_pkg::MODE_STACK_OFFSET16:
        addr = stackPtr + {byteOne, byteTwo};
      // RULE_15 high byte first
      cto_pkg::MODE_EXTENDED_ADDRESS:
        addr = {byteOne, byteTwo};
      // RULE_16 high then low offset
      cto_pkg::MODE_INDEXED_OFF16:
        addr = indexPair + {byteOne, byteTwo};
      // RULE_11 index plus offset
      cto_pkg::MODE_INDEXED_OFF8, cto_pkg::MODE_INDEXED_OFF8_POSTINC:
        addr = indexPair + {8'h00, byteOne};
      default:
        addr = indexPair;
    endcase
  end

endmodule
`default_nettype wire

// ==== design/cto_flag_eval.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cto_regs.svh"

module cto_flag_eval (
  input  wire logic [7:0] value,
  input  wire logic [7:0] ccrIn,
  input  wire logic [7:0] compareWith,
  output logic [7:0]      ccrOut,
  output logic            isEqual
);

  // RULE_03 flags from test
  always_comb
  begin
    ccrOut = ccrIn;
    ccrOut[`CTO_CCR_N] = value[7];
    ccrOut[`CTO_CCR_Z] = (value == 8'h00);
    ccrOut[`CTO_CCR_V] = 1'b0;
    isEqual = (value == compareWith);
  end

endmodule
`default_nettype wire

// ==== verif/cto_core_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module cto_core_sva (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 instValid,
  input wire logic [7:0]           instByte,
  input wire logic                 svcValid,
  input wire logic                 instReady,
  input wire logic                 svcDone,
  input wire cto_pkg::cto_mem_t    mem,
  input wire cto_pkg::cto_regs_t   regs,
  input wire cto_pkg::cto_branch_t branch,
  input wire logic                 opDone,
  input wire logic                 opUnknown
);
  logic atOp;
  logic opTake;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Operand bytes share values with opcodes, so only a byte in an opcode slot counts
  assign opTake = instValid && instReady && !svcValid && (atOp || opDone || opUnknown);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      atOp <= 1'b1;
    else if (opTake)
      atOp <= 1'b0;
    else if (opDone || opUnknown || svcDone)
      atOp <= 1'b1;
  end
  a_acc_to_index:
  assert property (opTake && instByte == 8'h97 |=> opDone && regs.idxLow == $past(regs.acc) && $stable(regs.condition_flags_register))
    else $error("acc to index copy wrong");
  a_flags_to_acc:
  assert property (opTake && instByte == 8'h85 |=> opDone && regs.acc == $past(regs.condition_flags_register) && $stable(regs.condition_flags_register))
    else $error("flags to acc copy wrong");
  a_index_to_acc:
  assert property (opTake && instByte == 8'h9f |=> opDone && regs.acc == $past(regs.idxLow) && $stable(regs.condition_flags_register))
    else $error("index to acc copy wrong");
  a_stack_to_pair:
  assert property (opTake && instByte == 8'h95 |=> !opDone ##1 (opDone && $stable(regs.condition_flags_register)
    && {regs.idxHigh, regs.idxLow} == $past(regs.stackPtr, 2) + 16'h0001))
    else $error("stack to pair wrong");
  a_pair_to_stack:
  assert property (opTake && instByte == 8'h94 |=> !opDone ##1 (opDone && $stable(regs.condition_flags_register)
    && regs.stackPtr == $past({regs.idxHigh, regs.idxLow}, 2) - 16'h0001))
    else $error("pair to stack wrong");
  a_check_acc_flags:
  assert property (opTake && instByte == 8'h4d |=> opDone && $stable(regs.acc) && regs.condition_flags_register ==
    {1'b0, $past(regs.condition_flags_register[6:3]), $past(regs.acc[7]), $past(regs.acc) == 8'h00, $past(regs.condition_flags_register[0])})
    else $error("acc test flags wrong");
  a_check_index_flags:
  assert property (opTake && instByte == 8'h5d |=> opDone && $stable(regs.idxLow) && regs.condition_flags_register ==
    {1'b0, $past(regs.condition_flags_register[6:3]), $past(regs.idxLow[7]), $past(regs.idxLow) == 8'h00, $past(regs.condition_flags_register[0])})
    else $error("index test flags wrong");
  a_check_indexed_read:
  assert property (opTake && instByte == 8'h7d |=> !opDone ##1 (mem.rd && !instReady
    && mem.addr == $past({regs.idxHigh, regs.idxLow}, 2)) ##2 opDone)
    else $error("indexed test read wrong");
  a_branch_with_done:
  assert property (branch.valid |-> opDone && !mem.wr)
    else $error("branch result without done");
  cover property (branch.valid && branch.taken);
  cover property (svcDone);
  cover property (opUnknown);
endmodule
`default_nettype wire

// ==== verif/cto_core_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module cto_core_test;
  logic                 ref_clk;
  logic                 rst;
  logic                 instValid;
  logic [7:0]           instByte;
  logic                 svcValid;
  cto_pkg::cto_mode_t   svcMode;
  logic [7:0]           memRdata;
  logic                 instReady;
  logic [15:0]          svcAddr;
  logic                 svcDone;
  cto_pkg::cto_mem_t    mem;
  cto_pkg::cto_regs_t   regs;
  cto_pkg::cto_branch_t branch;
  logic                 opDone;
  logic                 opUnknown;
  logic [7:0]           memByte;
  logic [15:0]          rdAddr;
  logic [15:0]          wrAddr;
  logic [7:0]           wrData;
  logic [7:0]           eAcc;
  logic [7:0]           eCcr;
  logic [15:0]          eHx;
  logic [15:0]          eSp;
  int                   err_total;
  int                   comparisons;
  cto_core i_cto_core (.ref_clk(ref_clk), .rst(rst), .instValid(instValid), .instByte(instByte),
    .svcValid(svcValid), .svcMode(svcMode), .memRdata(memRdata), .instReady(instReady), .svcAddr(svcAddr),
    .svcDone(svcDone), .mem(mem), .regs(regs), .branch(branch), .opDone(opDone), .opUnknown(opUnknown));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Read data outside its cycle toggles so a late sample never sees a stale match
  always @(posedge ref_clk)
  begin
    memRdata <= #1 mem.rd ? memByte : ~memRdata;
    if (mem.rd)
      rdAddr <= mem.addr;
    if (mem.wr)
      wrAddr <= mem.addr;
    if (mem.wr)
      wrData <= mem.wdata;
  end
  task give_verdict;
    $display("comparisons %0d, err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task put(input logic [7:0] b);
    int n;
    instValid = 1'b1;
    instByte = b;
    for (n = 0; n < 20 && instReady !== 1'b1; n++)
      tick;
    tick;
  endtask
  task finish(input int cyc);
    int n;
    instValid = 1'b0;
    n = 1;
    while (opDone !== 1'b1 && n < 20)
    begin
      tick;
      n++;
    end
    check("done", 16'(opDone), 16'h0001);
    if (cyc > 0)
      check("cycles", 16'(n), 16'(cyc));
    tick;
  endtask
  task op_seq(input logic [7:0] op, input int nb, input logic [7:0] b1, input logic [7:0] b2, input int cyc);
    put(op);
    if (nb > 0)
      put(b1);
    if (nb > 1)
      put(b2);
    finish(cyc);
  endtask
  task expect_regs;
    check("acc", 16'(regs.acc), 16'(eAcc));
    check("pair", {regs.idxHigh, regs.idxLow}, eHx);
    check("stack", regs.stackPtr, eSp);
    check("flags", 16'(regs.condition_flags_register), 16'(eCcr));
  endtask
  task do_reset;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    check("ready", 16'(instReady), 16'h0000);
    eAcc = 8'h00;
    eCcr = 8'h68;
    eHx = 16'h0000;
    eSp = 16'h00ff;
    expect_regs;
    check("svc addr", svcAddr, 16'h0000);
    rst = 1'b0;
    tick;
    check("ready", 16'(instReady), 16'h0001);
  endtask
  task test_transfers;
    put(8'h85);
    check("done", 16'(opDone), 16'h0001);
    put(8'h97);
    finish(1);
    eAcc = eCcr;
    eHx[7:0] = eAcc;
    expect_regs;
    op_seq(8'h94, 0, 8'h00, 8'h00, 2);
    eSp = eHx - 16'h0001;
    expect_regs;
  endtask
  task chk_case(input logic pre, input logic [7:0] op, input int nb, input logic [7:0] b1,
    input logic [7:0] val, input logic [15:0] ea);
    memByte = val;
    if (pre)
      put(8'h9e);
    op_seq(op, nb, b1, 8'h00, (op == 8'h4d || op == 8'h5d) ? 1 : 4);
    eCcr = {1'b0, eCcr[6:3], val[7], val == 8'h00, eCcr[0]};
    expect_regs;
    if (ea != 16'hffff)
      check("read addr", rdAddr, ea);
  endtask
  task test_checks;
    chk_case(1'b0, 8'h7d, 0, 8'h00, 8'h80, 16'h0068);
    chk_case(1'b0, 8'h4d, 0, 8'h00, eAcc, 16'hffff);
    chk_case(1'b0, 8'h6d, 1, 8'h10, 8'h00, 16'h0078);
    chk_case(1'b0, 8'h5d, 0, 8'h00, eHx[7:0], 16'hffff);
    chk_case(1'b0, 8'h3d, 1, 8'h40, 8'hff, 16'h0040);
    chk_case(1'b1, 8'h6d, 1, 8'h05, 8'h00, 16'h006c);
    op_seq(8'h85, 0, 8'h00, 8'h00, 1);
    eAcc = eCcr;
    expect_regs;
    op_seq(8'h9f, 0, 8'h00, 8'h00, 1);
    eAcc = eHx[7:0];
    expect_regs;
  endtask
  task branch_case(input logic [7:0] op, input int nb, input logic [7:0] b1, input logic [7:0] b2,
    input logic [15:0] ea, input logic tk);
    op_seq(op, nb, b1, b2, 0);
    check("read addr", rdAddr, ea);
    check("taken", 16'(branch.taken), 16'(tk));
    check("disp", 16'(branch.disp), 16'(b2));
  endtask
  task test_postinc;
    memByte = eAcc;
    branch_case(8'h71, 1, 8'hfe, 8'hfe, 16'h0068, 1'b1);
    memByte = 8'h00;
    branch_case(8'h61, 2, 8'h10, 8'h02, 16'h0079, 1'b0);
    memByte = eAcc;
    branch_case(8'h31, 2, 8'h33, 8'h7f, 16'h0033, 1'b1);
    eHx = 16'h006a;
    expect_regs;
    memByte = 8'ha5;
    op_seq(8'h5e, 1, 8'h44, 8'h00, 0);
    check("read addr", rdAddr, 16'h0044);
    check("write addr", wrAddr, 16'h006a);
    check("write data", 16'(wrData), 16'h00a5);
    memByte = 8'h3c;
    op_seq(8'h7e, 1, 8'h55, 8'h00, 0);
    check("read addr", rdAddr, 16'h006b);
    check("write addr", wrAddr, 16'h0055);
    check("write data", 16'(wrData), 16'h003c);
    op_seq(8'h6e, 2, 8'hc3, 8'h66, 2);
    check("write addr", wrAddr, 16'h0066);
    check("write data", 16'(wrData), 16'h00c3);
    eHx = 16'h006c;
    expect_regs;
    op_seq(8'h95, 0, 8'h00, 8'h00, 2);
    eHx = eSp + 16'h0001;
    expect_regs;
  endtask
  task svc(input cto_pkg::cto_mode_t md, input int nb, input logic [7:0] b1, input logic [7:0] b2,
    input logic [15:0] ea);
    int n;
    svcMode = md;
    svcValid = 1'b1;
    tick;
    put(b1);
    if (nb > 1)
      put(b2);
    instValid = 1'b0;
    for (n = 0; n < 20 && svcDone !== 1'b1; n++)
      tick;
    check("svc done", 16'(svcDone), 16'h0001);
    check("svc addr", svcAddr, ea);
    svcValid = 1'b0;
    tick;
  endtask
  task test_service_and_unknown;
    int n;
    svc(cto_pkg::MODE_EXTENDED_ADDRESS, 2, 8'h12, 8'h34, 16'h1234);
    svc(cto_pkg::MODE_INDEXED_OFF16, 2, 8'h01, 8'h02, 16'h016a);
    svc(cto_pkg::MODE_STACK_OFFSET8, 1, 8'hf0, 8'h00, 16'h0157);
    svc(cto_pkg::MODE_STACK_OFFSET16, 2, 8'h80, 8'h01, 16'h8068);
    put(8'h9e);
    put(8'h00);
    instValid = 1'b0;
    for (n = 0; n < 20 && opUnknown !== 1'b1; n++)
      tick;
    check("unknown", 16'(opUnknown), 16'h0001);
    tick;
  endtask
  initial
  begin
    err_total = 0;
    comparisons = 0;
    instValid = 1'b0;
    instByte = 8'h00;
    svcValid = 1'b0;
    svcMode = cto_pkg::MODE_INHERENT;
    memByte = 8'h00;
    memRdata = 8'h5a;
    rdAddr = 16'hffff;
    wrAddr = 16'hffff;
    wrData = 8'h00;
    do_reset;
    test_transfers;
    test_checks;
    test_postinc;
    test_service_and_unknown;
    do_reset;
    give_verdict;
  end
  initial
  begin
    #(3000 * 8);
    err_total++;
    give_verdict;
  end
endmodule
bind cto_core cto_core_sva i_cto_core_sva (.ref_clk(ref_clk), .rst(rst), .instValid(instValid),
  .instByte(instByte), .svcValid(svcValid), .instReady(instReady), .svcDone(svcDone), .mem(mem),
  .regs(regs), .branch(branch), .opDone(opDone), .opUnknown(opUnknown));
`default_nettype wire
